// ---- rtl/data_memory.v ----
// Data memory built from flip-flops, one write port and one read port
`timescale 1ns/1ns
`default_nettype none
`include "exec_subset_defs.vh"
module data_memory (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Access
  input wire [`MEM_AW-1:0] addr,
  input wire wr_en,
  input wire [7:0] wr_data,
  output wire [7:0] rd_data
);
  reg [7:0] cells [0:`MEM_DEPTH-1];
  integer i;
  assign rd_data = cells[addr];
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < `MEM_DEPTH; i = i + 1) begin
        cells[i] <= `BYTE_ZERO;
      end
    end else if (wr_en) begin
      cells[addr] <= wr_data;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/exec_subset.v ----
// Execute stage for a subset of the 8-bit core instruction set
`timescale 1ns/1ns
`default_nettype none
`include "exec_subset_defs.vh"
module exec_subset (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Instruction issue
  input wire instr_valid,
  input wire [`OP_W-1:0] opcode,
  input wire [`MEM_AW-1:0] mem_addr,
  input wire [7:0] imm_data,
  input wire [`PC_W-1:0] jump_addr,
  // Core state
  output reg [`PC_W-1:0] program_counter,
  output reg [7:0] working_register,
  output reg carry_flag,
  output reg zero_flag,
  output reg half_carry_flag,
  output reg overflow_flag,
  output reg global_interrupt_enable,
  // Pipeline status
  output reg busy,
  output reg skip_taken,
  output reg [7:0] mem_read_data
);
  // ----------------------------------------
  // Sequencing states
  // ----------------------------------------
  localparam ST_RUN = 1'b0;
  localparam ST_DUMMY = 1'b1;

  reg state;
  reg next_state;
  reg [`PC_W-1:0] next_pc;
  reg [7:0] next_acc;
  reg next_c;
  reg next_z;
  reg next_ac;
  reg next_ov;
  reg next_emi;
  reg mem_we;
  reg [7:0] mem_wdata;
  reg stack_pop;
  reg skip;
  wire [7:0] mem_rdata;
  wire [`PC_W-1:0] stack_top;
  wire [8:0] sbc_sum;
  wire [4:0] sbc_low;
  wire [7:0] dec_val;
  wire [7:0] or_mem;
  wire [7:0] or_imm;

  // ----------------------------------------
  // Arithmetic helpers
  // ----------------------------------------
  function is_zero;
    input [7:0] v;
    begin
      is_zero = (v == `BYTE_ZERO);
    end
  endfunction

  function [7:0] rot_left;
    input [7:0] v;
    input in_bit;
    begin
      rot_left = {v[6:0], in_bit};
    end
  endfunction

  function [7:0] rot_right;
    input [7:0] v;
    input in_bit;
    begin
      rot_right = {in_bit, v[7:1]};
    end
  endfunction

  // Subtract with borrow is an add of the inverted operand
  assign sbc_sum = {1'b0, working_register} + {1'b0, ~mem_rdata} + {8'h00, carry_flag};
  assign sbc_low = {1'b0, working_register[3:0]} + {1'b0, ~mem_rdata[3:0]} + {4'h0, carry_flag};
  assign dec_val = mem_rdata - `BYTE_ONE;
  assign or_mem = working_register | mem_rdata;
  assign or_imm = working_register | imm_data;

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  data_memory u_mem (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .addr(mem_addr),
    .wr_en(mem_we),
    .wr_data(mem_wdata),
    .rd_data(mem_rdata)
  );

  return_stack u_stack (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .push(1'b0),
    .push_data(`PC_RESET),
    .pop(stack_pop),
    .top(stack_top)
  );

  // ----------------------------------------
  // Execute decode
  // ----------------------------------------
  always @* begin
    next_state = ST_RUN;
    next_pc = program_counter;
    next_acc = working_register;
    next_c = carry_flag;
    next_z = zero_flag;
    next_ac = half_carry_flag;
    next_ov = overflow_flag;
    next_emi = global_interrupt_enable;
    mem_we = 1'b0;
    mem_wdata = `BYTE_ZERO;
    stack_pop = 1'b0;
    skip = 1'b0;
    if (state == ST_DUMMY) begin
      // Discarded prefetch: issue is ignored while busy
      next_pc = program_counter + 11'h001;
    end else if (instr_valid) begin
      next_pc = program_counter + 11'h001;
      case (opcode)
        `OP_NOP: begin
          next_pc = program_counter + 11'h001;
        end
        `OP_JUMP: begin
          next_pc = jump_addr;
        end
        `OP_MOV_A_M: begin
          next_acc = mem_rdata;
        end
        `OP_MOV_A_X: begin
          next_acc = imm_data;
        end
        `OP_MOV_M_A: begin
          mem_we = 1'b1;
          mem_wdata = working_register;
        end
        `OP_OR_A_M: begin
          next_acc = or_mem;
          next_z = is_zero(or_mem);
        end
        `OP_OR_A_X: begin
          next_acc = or_imm;
          next_z = is_zero(or_imm);
        end
        `OP_OR_M: begin
          mem_we = 1'b1;
          mem_wdata = or_mem;
          next_z = is_zero(or_mem);
        end
        `OP_RET: begin
          stack_pop = 1'b1;
          next_pc = stack_top;
          next_state = ST_DUMMY;
        end
        `OP_RET_A_X: begin
          stack_pop = 1'b1;
          next_pc = stack_top;
          next_acc = imm_data;
          next_state = ST_DUMMY;
        end
        `OP_INTERRUPT_RETURN: begin
          stack_pop = 1'b1;
          next_pc = stack_top;
          next_emi = 1'b1;
          next_state = ST_DUMMY;
        end
        `OP_RL: begin
          mem_we = 1'b1;
          mem_wdata = rot_left(mem_rdata, mem_rdata[7]);
        end
        `OP_RLA: begin
          next_acc = rot_left(mem_rdata, mem_rdata[7]);
        end
        `OP_RLC: begin
          mem_we = 1'b1;
          mem_wdata = rot_left(mem_rdata, carry_flag);
          next_c = mem_rdata[7];
        end
        `OP_ROTATE_LEFT_CARRY_TO_WORKING: begin
          next_acc = rot_left(mem_rdata, carry_flag);
          next_c = mem_rdata[7];
        end
        `OP_RR: begin
          mem_we = 1'b1;
          mem_wdata = rot_right(mem_rdata, mem_rdata[0]);
        end
        `OP_RRA: begin
          next_acc = rot_right(mem_rdata, mem_rdata[0]);
        end
        `OP_RRC: begin
          mem_we = 1'b1;
          mem_wdata = rot_right(mem_rdata, carry_flag);
          next_c = mem_rdata[0];
        end
        `OP_ROTATE_RIGHT_CARRY_TO_WORKING: begin
          next_acc = rot_right(mem_rdata, carry_flag);
          next_c = mem_rdata[0];
        end
        `OP_SBC, `OP_SUBTRACT_BORROW_TO_MEMORY: begin
          if (opcode == `OP_SUBTRACT_BORROW_TO_MEMORY) begin
            mem_we = 1'b1;
            mem_wdata = sbc_sum[7:0];
          end else begin
            next_acc = sbc_sum[7:0];
          end
          next_c = sbc_sum[8];
          next_ac = sbc_low[4];
          next_z = is_zero(sbc_sum[7:0]);
          // Signed overflow: like-signed operands giving an unlike sign
          next_ov = (working_register[7] == ~mem_rdata[7]) && (sbc_sum[7] != working_register[7]);
        end
        `OP_SDZ: begin
          mem_we = 1'b1;
          mem_wdata = dec_val;
          skip = is_zero(dec_val);
        end
        `OP_DECREMENT_TO_WORKING_SKIP_ON_ZERO: begin
          next_acc = dec_val;
          skip = is_zero(dec_val);
        end
        default: begin
          // Opcodes outside the subset simply advance
          next_pc = program_counter + 11'h001;
        end
      endcase
      if (skip) begin
        next_state = ST_DUMMY;
      end
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_RUN;
      program_counter <= `PC_RESET;
      working_register <= `BYTE_ZERO;
      carry_flag <= 1'b0;
      zero_flag <= 1'b0;
      half_carry_flag <= 1'b0;
      overflow_flag <= 1'b0;
      global_interrupt_enable <= 1'b0;
      busy <= 1'b0;
      skip_taken <= 1'b0;
      mem_read_data <= `BYTE_ZERO;
    end else begin
      state <= next_state;
      program_counter <= next_pc;
      working_register <= next_acc;
      carry_flag <= next_c;
      zero_flag <= next_z;
      half_carry_flag <= next_ac;
      overflow_flag <= next_ov;
      global_interrupt_enable <= next_emi;
      busy <= (next_state == ST_DUMMY);
      skip_taken <= skip;
      mem_read_data <= mem_rdata;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/exec_subset_defs.vh ----
// Constants for the instruction execute subset
`ifndef EXEC_SUBSET_DEFS_VH
`define EXEC_SUBSET_DEFS_VH
`define PC_W 11
`define MEM_AW 7
`define MEM_DEPTH 128
`define STACK_DEPTH 8
`define SP_W 3
`define OP_W 5
`define OP_NOP 5'h00
`define OP_JUMP 5'h01
`define OP_MOV_A_M 5'h02
`define OP_MOV_A_X 5'h03
`define OP_MOV_M_A 5'h04
`define OP_OR_A_M 5'h05
`define OP_OR_A_X 5'h06
`define OP_OR_M 5'h07
`define OP_RET 5'h08
`define OP_RET_A_X 5'h09
`define OP_INTERRUPT_RETURN 5'h0A
`define OP_RL 5'h0B
`define OP_RLA 5'h0C
`define OP_RLC 5'h0D
`define OP_ROTATE_LEFT_CARRY_TO_WORKING 5'h0E
`define OP_RR 5'h0F
`define OP_RRA 5'h10
`define OP_RRC 5'h11
`define OP_ROTATE_RIGHT_CARRY_TO_WORKING 5'h12
`define OP_SBC 5'h13
`define OP_SUBTRACT_BORROW_TO_MEMORY 5'h14
`define OP_SDZ 5'h15
`define OP_DECREMENT_TO_WORKING_SKIP_ON_ZERO 5'h16
`define PC_RESET 11'h000
`define BYTE_ZERO 8'h00
`define BYTE_ONE 8'h01
`endif

// ---- rtl/return_stack.v ----
// Return stack of program counter values
`timescale 1ns/1ns
`default_nettype none
`include "exec_subset_defs.vh"
module return_stack (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Push and pop
  input wire push,
  input wire [`PC_W-1:0] push_data,
  input wire pop,
  output wire [`PC_W-1:0] top
);
  reg [`PC_W-1:0] slots [0:`STACK_DEPTH-1];
  reg [`SP_W-1:0] sp;
  integer i;
  // Wraps silently on overflow, as a small hardware stack does
  assign top = slots[sp - 3'h1];
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp <= 3'h0;
      for (i = 0; i < `STACK_DEPTH; i = i + 1) begin
        slots[i] <= `PC_RESET;
      end
    end else if (push) begin
      slots[sp] <= push_data;
      sp <= sp + 3'h1;
    end else if (pop) begin
      sp <= sp - 3'h1;
    end
  end
endmodule
`default_nettype wire

// ---- verification/exec_subset_chk.sv ----
// Port assertions for the execute subset
`timescale 1ns/1ns
`default_nettype none
`include "exec_subset_defs.vh"
module exec_subset_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Instruction issue
  input wire logic instr_valid,
  input wire logic [`OP_W-1:0] opcode,
  input wire logic [`MEM_AW-1:0] mem_addr,
  input wire logic [7:0] imm_data,
  input wire logic [`PC_W-1:0] jump_addr,
  // Core state
  input wire logic [`PC_W-1:0] program_counter,
  input wire logic [7:0] working_register,
  input wire logic carry_flag,
  input wire logic zero_flag,
  input wire logic half_carry_flag,
  input wire logic overflow_flag,
  input wire logic global_interrupt_enable,
  // Pipeline status
  input wire logic busy,
  input wire logic skip_taken,
  input wire logic [7:0] mem_read_data
);
  wire take;
  // Issues during the dummy cycle are refused, so only these count
  assign take = instr_valid && !busy;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_jump;
    take && opcode == `OP_JUMP |=> program_counter == $past(jump_addr);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target not loaded");
  property p_mov_imm;
    take && opcode == `OP_MOV_A_X |=> working_register == $past(imm_data)
      && $stable({carry_flag, zero_flag, half_carry_flag, overflow_flag});
  endproperty
  a_mov_imm: assert property (p_mov_imm) else $error("immediate move wrong");
  property p_nop;
    take && opcode == `OP_NOP |=> program_counter == $past(program_counter) + 11'h001
      && $stable(working_register) && !busy;
  endproperty
  a_nop: assert property (p_nop) else $error("no-op changed state");
  property p_or_imm;
    take && opcode == `OP_OR_A_X |=> working_register == ($past(working_register) | $past(imm_data))
      && zero_flag == (working_register == 8'h00) && $stable(carry_flag);
  endproperty
  a_or_imm: assert property (p_or_imm) else $error("or immediate wrong");
  property p_ret_len;
    take && (opcode == `OP_RET || opcode == `OP_RET_A_X || opcode == `OP_INTERRUPT_RETURN) |=> busy ##1 !busy;
  endproperty
  a_ret_len: assert property (p_ret_len) else $error("return not two cycles");
  property p_interrupt_return;
    take && opcode == `OP_INTERRUPT_RETURN |=> global_interrupt_enable;
  endproperty
  a_interrupt_return: assert property (p_interrupt_return) else $error("interrupt enable not set");
  property p_rotate_left_carry_to_working;
    take && opcode == `OP_ROTATE_LEFT_CARRY_TO_WORKING |=> working_register[0] == $past(carry_flag);
  endproperty
  a_rotate_left_carry_to_working: assert property (p_rotate_left_carry_to_working) else $error("old carry not in bit 0");
  property p_skip;
    skip_taken |-> busy ##1 (!busy && !skip_taken);
  endproperty
  a_skip: assert property (p_skip) else $error("skip not one dummy cycle");
  property p_dummy;
    busy |=> program_counter == $past(program_counter) + 11'h001 && !skip_taken;
  endproperty
  a_dummy: assert property (p_dummy) else $error("dummy cycle wrong");
  c_skip: cover property (take && opcode == `OP_SDZ ##1 skip_taken);
  c_interrupt_return: cover property (take && opcode == `OP_INTERRUPT_RETURN);
  c_ov: cover property (take && opcode == `OP_SBC ##1 overflow_flag);
endmodule
bind exec_subset exec_subset_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .instr_valid(instr_valid),
  .opcode(opcode), .mem_addr(mem_addr), .imm_data(imm_data), .jump_addr(jump_addr),
  .program_counter(program_counter), .working_register(working_register), .carry_flag(carry_flag),
  .zero_flag(zero_flag), .half_carry_flag(half_carry_flag), .overflow_flag(overflow_flag),
  .global_interrupt_enable(global_interrupt_enable), .busy(busy), .skip_taken(skip_taken),
  .mem_read_data(mem_read_data));
`default_nettype wire

// ---- verification/tb_exec_subset.sv ----
// Self-checking bench for the execute subset
`timescale 1ns/1ns
`default_nettype none
`include "exec_subset_defs.vh"
module tb_exec_subset;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [4:0] opcode = 5'h00;
  logic [6:0] mem_addr = 7'h00;
  logic [7:0] imm_data = 8'h00;
  logic [10:0] jump_addr = 11'h000;
  wire [10:0] program_counter;
  wire [7:0] working_register, mem_read_data;
  wire carry_flag, zero_flag, half_carry_flag, overflow_flag, global_interrupt_enable, busy, skip_taken;
  logic [7:0] mem [0:127];
  logic [10:0] m_pc = 11'h000;
  logic [7:0] m_a = 8'h00;
  logic m_c = 1'b0, m_z = 1'b0, m_ac = 1'b0, m_ov = 1'b0, m_gie = 1'b0, m_skip = 1'b0;
  logic [32:0] q [$];
  logic [32:0] e;
  logic [10:0] ea;
  int n_fail = 0;
  int cmp_count = 0;
  logic [4:0] dir [0:7] = '{`OP_MOV_A_X, `OP_MOV_M_A, `OP_SDZ, `OP_MOV_A_M,
                           `OP_MOV_A_X, `OP_MOV_M_A, `OP_DECREMENT_TO_WORKING_SKIP_ON_ZERO, `OP_MOV_A_M};
  wire [10:0] w_acc = {3'h0, working_register};
  wire [10:0] w_flg = {7'h0, carry_flag, zero_flag, half_carry_flag, overflow_flag};
  wire [10:0] w_st = {9'h0, global_interrupt_enable, skip_taken};
  exec_subset u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .instr_valid(instr_valid), .opcode(opcode),
    .mem_addr(mem_addr), .imm_data(imm_data), .jump_addr(jump_addr), .program_counter(program_counter),
    .working_register(working_register), .carry_flag(carry_flag), .zero_flag(zero_flag),
    .half_carry_flag(half_carry_flag), .overflow_flag(overflow_flag),
    .global_interrupt_enable(global_interrupt_enable), .busy(busy), .skip_taken(skip_taken),
    .mem_read_data(mem_read_data));
  initial forever #10 sys_clk = ~sys_clk;
  task check(input logic [10:0] seen, input logic [10:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("Compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // --------------------------------
  // Drive one instruction, note the expected state
  // --------------------------------
  task issue(input logic [4:0] op, input logic [6:0] a, input logic [7:0] x);
    logic [7:0] m, r;
    logic [8:0] s;
    logic [4:0] lo;
    logic [10:0] j;
    logic dmy;
    int d;
    j = 11'($urandom);
    m = mem[a];
    r = m;
    dmy = 1'b0;
    m_skip = 1'b0;
    m_pc = m_pc + 11'h001;
    case (op)
      `OP_JUMP: m_pc = j;
      `OP_MOV_A_M: m_a = m;
      `OP_MOV_A_X: m_a = x;
      `OP_MOV_M_A: mem[a] = m_a;
      `OP_OR_A_M, `OP_OR_A_X, `OP_OR_M: begin
        r = m_a | ((op == `OP_OR_A_X) ? x : m);
        m_z = (r == 8'h00);
      end
      `OP_RET, `OP_RET_A_X, `OP_INTERRUPT_RETURN: begin
        // Stack is never pushed here, so every pop yields zero
        m_pc = 11'h000;
        dmy = 1'b1;
        if (op == `OP_RET_A_X) m_a = x;
        if (op == `OP_INTERRUPT_RETURN) m_gie = 1'b1;
      end
      `OP_RL, `OP_RLA: r = {m[6:0], m[7]};
      `OP_RR, `OP_RRA: r = {m[0], m[7:1]};
      `OP_RLC, `OP_ROTATE_LEFT_CARRY_TO_WORKING: begin
        r = {m[6:0], m_c};
        m_c = m[7];
      end
      `OP_RRC, `OP_ROTATE_RIGHT_CARRY_TO_WORKING: begin
        r = {m_c, m[7:1]};
        m_c = m[0];
      end
      `OP_SBC, `OP_SUBTRACT_BORROW_TO_MEMORY: begin
        s = {1'b0, m_a} + {1'b0, ~m} + {8'h00, m_c};
        lo = {1'b0, m_a[3:0]} + {1'b0, ~m[3:0]} + {4'h0, m_c};
        // Overflow judged on the true signed difference, not on sign bits
        d = int'($signed(m_a)) - int'($signed(m)) - int'(!m_c);
        m_ov = (d < -128) || (d > 127);
        m_ac = lo[4];
        m_c = s[8];
        m_z = (s[7:0] == 8'h00);
        r = s[7:0];
      end
      `OP_SDZ, `OP_DECREMENT_TO_WORKING_SKIP_ON_ZERO: begin
        r = m - 8'h01;
        dmy = (r == 8'h00);
        m_skip = dmy;
      end
      default: ;
    endcase
    if (op inside {`OP_OR_M, `OP_RL, `OP_RR, `OP_RLC, `OP_RRC, `OP_SUBTRACT_BORROW_TO_MEMORY, `OP_SDZ}) mem[a] = r;
    if (op inside {`OP_OR_A_M, `OP_OR_A_X, `OP_RLA, `OP_RRA, `OP_ROTATE_LEFT_CARRY_TO_WORKING, `OP_ROTATE_RIGHT_CARRY_TO_WORKING, `OP_SBC, `OP_DECREMENT_TO_WORKING_SKIP_ON_ZERO}) m_a = r;
    q.push_back({m, m_pc, m_a, m_c, m_z, m_ac, m_ov, m_gie, m_skip});
    opcode <= op;
    mem_addr <= a;
    imm_data <= x;
    jump_addr <= j;
    instr_valid <= 1'b1;
    @(posedge sys_clk);
    if (dmy) begin
      // Issued during the dummy cycle, so it must be ignored
      opcode <= `OP_JUMP;
      m_pc = m_pc + 11'h001;
      @(posedge sys_clk);
    end
  endtask
  // --------------------------------
  // Monitor: compare each accepted instruction with its note
  // --------------------------------
  always @(posedge sys_clk) begin
    if (rst_n && instr_valid && !busy) begin
      #1;
      e = q.pop_front();
      ea = {3'h0, e[13:6]};
      check(program_counter, e[24:14]);
      check(w_acc, ea);
      check({3'h0, mem_read_data}, {3'h0, e[32:25]});
      check(w_flg, {7'h0, e[5:2]});
      check(w_st, {9'h0, e[1:0]});
    end
  end
  initial begin
    repeat (4000) @(posedge sys_clk);
    n_fail++;
    end_sim;
  end
  initial begin
    logic [6:0] a;
    void'($urandom(44735));
    for (int i = 0; i < 128; i++) mem[i] = 8'h00;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1 check(program_counter | w_acc | w_flg | w_st | {3'h0, mem_read_data}, 11'h000);
    @(posedge sys_clk);
    for (int k = 0; k < 8; k++) issue(dir[k], 7'h05, 8'h01);
    for (int o = 0; o < 23; o++) issue(5'(o), 7'h02, 8'($urandom));
    for (int n = 0; n < 600; n++) begin
      a = 7'($urandom_range(7, 0));
      issue(5'($urandom_range(22, 0)), a, 8'($urandom));
      issue(`OP_MOV_A_M, a, 8'($urandom));
    end
    instr_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
    end_sim;
  end
endmodule
`default_nettype wire
